// File: fss_vic_top.sv
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module fss_vic_top
	import fss_pkg::*;
#(
	parameter int unsigned      N_SRC   = 32,
	parameter logic [N_SRC-1:0] EXT_SRC = 32'h0007_0001
) (
	input  wire logic             I_REF_CLK,
	input  wire logic             I_RESET,
	input  wire logic             I_WB_CYC,
	input  wire logic             I_WB_STB,
	input  wire logic             I_WB_WE,
	input  wire logic [ADR_W-1:0] I_WB_ADR,
	input  wire logic [SEL_W-1:0] I_WB_SEL,
	input  wire logic [DAT_W-1:0] I_WB_DAT,
	output logic      [DAT_W-1:0] O_WB_DAT,
	output logic                  O_WB_ACK,
	input  wire logic             I_FAST_REQUEST_INPUT,
	input  wire logic [N_SRC-1:2] I_IRQ_SRC,
	output logic                  O_NORMAL_REQUEST_OUT_N,
	output logic                  O_FAST_REQUEST_OUT_N,
	output logic                  O_EVT_IRQ
);

	typedef struct packed {
		logic [N_SRC-1:0]                 sync1;
		logic [N_SRC-1:0]                 sync2;
		logic [N_SRC-1:0]                 prev;
		logic [N_SRC-1:0][TYPE_W-1:0]     smr_type;
		logic [N_SRC-1:0][PRIO_W-1:0]     smr_prio;
		logic [N_SRC-1:0]                 enable;
		logic [N_SRC-1:0]                 pend;
		logic [DAT_W-1:0]                 spu;
		logic                             cur_valid;
		logic [PRIO_W-1:0]                cur_prio;
		logic [SRC_W-1:0]                 cur_src;
		logic [STK_DEPTH-1:0][PRIO_W-1:0] stk;
		logic [SP_W-1:0]                  sp;
		logic                             spur;
		logic                             norm_n;
		logic                             fast_n;
		logic [EVT_W-1:0]                 evt_stat;
		logic [EVT_W-1:0]                 evt_mask;
		logic                             evt_irq;
		fss_bus_st_t                      st;
		logic                             ack;
		logic                             use_mem;
		logic [DAT_W-1:0]                 dat;
	} fss_state_t;

	fss_state_t state_reg;
	fss_state_t state_next;

	fss_vec_if #(.AW(SRC_W), .DW(DAT_W)) vec ();

	fss_vec_mem #(
		.DEPTH (N_SRC),
		.AW    (SRC_W),
		.DW    (DAT_W)
	) u_vec_mem (
		.i_clk   (I_REF_CLK),
		.i_reset (I_RESET),
		.port    (vec.mem)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [1:0] trig_decode(
		input logic [TYPE_W-1:0] t,
		input logic              ext
	);
		logic [1:0] m;
		m = '0;
		m[TRIG_EDGE_BIT] = t[TRIG_EDGE_BIT];
		m[TRIG_POL_BIT]  = ext ? t[TRIG_POL_BIT] : 1'b1;
		return m;
	endfunction : trig_decode

	function automatic logic table_hit(
		input logic [ADR_W-1:0] a,
		input logic [ADR_W-1:0] base
	);
		return (a >= base) && (a < base + TABLE_SPAN);
	endfunction : table_hit

	function automatic logic [DAT_W-1:0] sel_mask(
		input logic [SEL_W-1:0] s
	);
		logic [DAT_W-1:0] m;
		m = '0;
		for (int b = 0; b < SEL_W; b++) begin
			m[b*8 +: 8] = {8{s[b]}};
		end
		return m;
	endfunction : sel_mask

	// ------------------------------------------------------------
	// combinational decode
	// ------------------------------------------------------------
	logic [N_SRC-1:0]  raw;
	logic [N_SRC-1:0]  act;
	logic [N_SRC-1:0]  set_vec;
	logic [N_SRC-1:0]  clr_vec;
	logic [DAT_W-1:0]  wd;
	logic [EVT_W-1:0]  evt_new;
	logic [SRC_W-1:0]  idx;
	logic [SRC_W-1:0]  cand_src;
	logic [PRIO_W-1:0] cand_prio;
	logic [1:0]        mode;
	logic              cand_found;
	logic              cand_ok;
	logic              fast_on;
	logic              req;
	logic              wr;
	logic              rd;
	logic              ivr_rd;
	logic              fvr_rd;
	logic              ivr_good;
	logic              fvr_good;
	logic              eoi_wr;
	logic              hit;

	// software source has no pin; it is raised only by the set command
	assign raw = {I_IRQ_SRC, 1'b0, I_FAST_REQUEST_INPUT};
	assign act = state_reg.pend & state_reg.enable;

	always_comb begin
		cand_found = 1'b0;
		cand_src   = '0;
		cand_prio  = '0;
		// source 0 never enters the encoder; ties go to lowest number
		for (int i = 1; i < N_SRC; i++) begin
			if (act[i] && (!cand_found ||
					state_reg.smr_prio[i] > cand_prio)) begin
				cand_found = 1'b1;
				cand_src   = SRC_W'(i);
				cand_prio  = state_reg.smr_prio[i];
			end
		end
	end

	assign cand_ok = cand_found && (!state_reg.cur_valid ||
		cand_prio > state_reg.cur_prio);
	assign fast_on  = act[FAST_SRC];
	assign req      = I_WB_CYC && I_WB_STB && state_reg.st == BUS_IDLE;
	assign wr       = req && I_WB_WE;
	assign rd       = req && !I_WB_WE;
	assign wd       = I_WB_DAT & sel_mask(I_WB_SEL);
	assign idx      = I_WB_ADR[IDX_LSB +: SRC_W];
	assign ivr_rd   = rd && I_WB_ADR == IVR_OFS;
	assign fvr_rd   = rd && I_WB_ADR == FVR_OFS;
	// no candidate covers a withdrawn, dropped or disabled request
	assign ivr_good = ivr_rd && !state_reg.spur && cand_ok;
	assign fvr_good = fvr_rd && !state_reg.spur && fast_on;
	assign eoi_wr   = wr && I_WB_ADR == EOICR_OFS;

	assign vec.we    = wr && table_hit(I_WB_ADR, SVR_BASE);
	assign vec.waddr = idx;
	assign vec.wdata = I_WB_DAT;
	assign vec.wsel  = I_WB_SEL;
	assign vec.raddr = ivr_rd ? cand_src :
		fvr_rd ? SRC_W'(FAST_SRC) : idx;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		mode       = '0;
		hit        = 1'b0;
		evt_new    = '0;
		set_vec    = (wr && I_WB_ADR == ISCR_OFS) ? wd[N_SRC-1:0] : '0;
		clr_vec    = (wr && I_WB_ADR == ICCR_OFS) ? wd[N_SRC-1:0] : '0;
		if (ivr_good) begin
			clr_vec[cand_src] = 1'b1;
		end
		if (fvr_good) begin
			clr_vec[FAST_SRC] = 1'b1;
		end

		state_next.sync1 = raw;
		state_next.sync2 = state_reg.sync1;
		state_next.prev  = state_reg.sync2;

		for (int i = 0; i < N_SRC; i++) begin
			mode = trig_decode(state_reg.smr_type[i], EXT_SRC[i]);
			if (mode[TRIG_EDGE_BIT]) begin
				hit = mode[TRIG_POL_BIT] ?
					(state_reg.sync2[i] && !state_reg.prev[i]) :
					(!state_reg.sync2[i] && state_reg.prev[i]);
				// a new edge or set wins over a clear in the same cycle
				state_next.pend[i] = (state_reg.pend[i] && !clr_vec[i])
					|| hit || set_vec[i];
			end else begin
				state_next.pend[i] = mode[TRIG_POL_BIT] ?
					state_reg.sync2[i] : !state_reg.sync2[i];
			end
		end

		if (wr && table_hit(I_WB_ADR, SMR_BASE) && I_WB_SEL[0]) begin
			state_next.smr_type[idx] = wd[TYPE_LSB +: TYPE_W];
			state_next.smr_prio[idx] = wd[PRIO_LSB +: PRIO_W];
		end
		if (wr && I_WB_ADR == IECR_OFS) begin
			state_next.enable = state_reg.enable | wd[N_SRC-1:0];
		end
		if (wr && I_WB_ADR == IDCR_OFS) begin
			state_next.enable = state_reg.enable & ~wd[N_SRC-1:0];
		end
		if (wr && I_WB_ADR == SPU_OFS) begin
			state_next.spu = (state_reg.spu & ~sel_mask(I_WB_SEL)) | wd;
		end
		if (wr && I_WB_ADR == EVMSK_OFS) begin
			state_next.evt_mask = wd[EVT_W-1:0];
		end

		// normal vector fetch: push level, or enter spurious handling
		if (ivr_good) begin
			if (state_reg.cur_valid &&
					state_reg.sp < SP_W'(STK_DEPTH)) begin
				state_next.stk[state_reg.sp[STK_IDX_W-1:0]] =
					state_reg.cur_prio;
				state_next.sp = state_reg.sp + 1'b1;
			end
			state_next.cur_valid = 1'b1;
			state_next.cur_prio  = cand_prio;
			state_next.cur_src   = cand_src;
		end else if (ivr_rd) begin
			state_next.spur            = 1'b1;
			evt_new[EVT_SPUR_IVR]      = 1'b1;
		end
		if (fvr_rd && !fvr_good) begin
			state_next.spur            = 1'b1;
			evt_new[EVT_SPUR_FVR]      = 1'b1;
		end

		// a spurious acknowledge must not pop the stack it never pushed
		if (eoi_wr) begin
			evt_new[EVT_EOI] = 1'b1;
			if (state_reg.spur) begin
				state_next.spur = 1'b0;
			end else if (state_reg.sp != '0) begin
				state_next.cur_prio = state_reg.stk[
					STK_IDX_W'(state_reg.sp - 1'b1)];
				state_next.sp = state_reg.sp - 1'b1;
			end else begin
				state_next.cur_valid = 1'b0;
			end
		end

		state_next.norm_n = !(cand_ok && !ivr_rd && !state_next.spur);
		state_next.fast_n = !(fast_on && !fvr_rd && !state_next.spur);

		state_next.evt_stat = ((rd && I_WB_ADR == EVST_OFS) ?
			'0 : state_reg.evt_stat) | evt_new;
		state_next.evt_irq = |(state_next.evt_stat & state_next.evt_mask);

		// ------------------------------------------------------------
		// wishbone answer: ack two edges after the request is seen
		// ------------------------------------------------------------
		case (state_reg.st)
			BUS_IDLE: begin
				if (req) begin
					state_next.st      = BUS_WAIT;
					state_next.use_mem = rd && (ivr_good || fvr_good ||
						table_hit(I_WB_ADR, SVR_BASE));
					state_next.dat     = '0;
					if (rd) begin
						if (table_hit(I_WB_ADR, SMR_BASE)) begin
							state_next.dat[TYPE_LSB +: TYPE_W] =
								state_reg.smr_type[idx];
							state_next.dat[PRIO_LSB +: PRIO_W] =
								state_reg.smr_prio[idx];
						end
						case (I_WB_ADR)
							IVR_OFS,
							FVR_OFS,
							SPU_OFS:   state_next.dat = state_reg.spu;
							ISR_OFS:   state_next.dat[SRC_W-1:0] =
								state_reg.cur_src;
							IPR_OFS:   state_next.dat[N_SRC-1:0] =
								state_reg.pend;
							IMR_OFS:   state_next.dat[N_SRC-1:0] =
								state_reg.enable;
							CISR_OFS: begin
								state_next.dat[CISR_NORM_BIT] =
									!state_reg.norm_n;
								state_next.dat[CISR_FAST_BIT] =
									!state_reg.fast_n;
							end
							EVST_OFS:  state_next.dat[EVT_W-1:0] =
								state_reg.evt_stat;
							EVMSK_OFS: state_next.dat[EVT_W-1:0] =
								state_reg.evt_mask;
							default: ;
						endcase
					end
				end
			end
			BUS_WAIT: begin
				state_next.st  = BUS_DONE;
				state_next.ack = 1'b1;
				if (state_reg.use_mem) begin
					state_next.dat = vec.rdata;
				end
			end
			BUS_DONE: begin
				state_next.st  = BUS_IDLE;
				state_next.ack = 1'b0;
			end
			default: begin
				state_next.st  = BUS_IDLE;
				state_next.ack = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			state_reg        <= '0;
			state_reg.norm_n <= 1'b1;
			state_reg.fast_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign O_WB_DAT               = state_reg.dat;
	assign O_WB_ACK               = state_reg.ack;
	assign O_NORMAL_REQUEST_OUT_N = state_reg.norm_n;
	assign O_FAST_REQUEST_OUT_N   = state_reg.fast_n;
	assign O_EVT_IRQ              = state_reg.evt_irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_RESET);

	logic sw_edge;
	assign sw_edge = state_reg.smr_type[SW_SRC][TRIG_EDGE_BIT];

	set_cmd_a: assert property (
		wr && I_WB_ADR == ISCR_OFS && wd[SW_SRC] && sw_edge
		|=> state_reg.pend[SW_SRC]
	) else $error("edge source not pended by set command");

	level_cmd_a: assert property (
		wr && I_WB_ADR == ISCR_OFS && wd[SW_SRC] && !sw_edge
		|=> !state_reg.pend[SW_SRC]
	) else $error("level source pended by set command");

	fast_path_a: assert property (
		!O_FAST_REQUEST_OUT_N
		|-> $past(state_reg.pend[FAST_SRC] && state_reg.enable[FAST_SRC])
	) else $error("fast output without fast source active");

	fast_fall_a: assert property (
		state_reg.smr_type[FAST_SRC] == TRIG_FALL_EDGE &&
		state_reg.prev[FAST_SRC] && !state_reg.sync2[FAST_SRC]
		|=> state_reg.pend[FAST_SRC]
	) else $error("falling fast edge not pended");

	fast_vec_a: assert property (
		fvr_good ##1 1'b1 |=> O_WB_ACK && O_WB_DAT == $past(vec.rdata)
	) else $error("fast vector read did not return entry zero");

	sw_rise_a: assert property (
		$rose(state_reg.pend[SW_SRC])
		|-> $past(wr && I_WB_ADR == ISCR_OFS && wd[SW_SRC])
	) else $error("software source raised without set command");

	spur_vec_a: assert property (
		ivr_rd && !ivr_good
		|-> ##1 state_reg.spur ##1 O_WB_ACK && O_WB_DAT == state_reg.spu
	) else $error("empty normal read did not give spurious vector");

	fvr_spur_a: assert property (
		fvr_rd && !fast_on |=> state_reg.spur
	) else $error("empty fast read did not enter spurious handling");

	spur_hold_a: assert property (
		state_reg.spur |-> O_NORMAL_REQUEST_OUT_N && O_FAST_REQUEST_OUT_N
	) else $error("request asserted during spurious handling");

	eoi_end_a: assert property (
		eoi_wr && state_reg.spur |=> !state_reg.spur
	) else $error("end of service did not end spurious handling");

	ivr_drop_a: assert property (
		ivr_good |=> O_NORMAL_REQUEST_OUT_N
	) else $error("normal request still asserted after vector read");

	eoi_pop_a: assert property (
		eoi_wr && !state_reg.spur && state_reg.sp != '0
		|=> state_reg.cur_prio ==
			$past(state_reg.stk[STK_IDX_W'(state_reg.sp - 1'b1)])
	) else $error("end of service did not restore stacked level");

	spur_entry_c: cover property (ivr_rd && !ivr_good);
	fast_read_c:  cover property (fvr_good);
	nest_push_c:  cover property (ivr_good && state_reg.cur_valid);
	spur_end_c:   cover property (eoi_wr && state_reg.spur);

endmodule : fss_vic_top

// File: fss_pkg.sv
package fss_pkg;

	// ------------------------------------------------------------
	// bus, field and stack geometry
	// ------------------------------------------------------------
	localparam int unsigned ADR_W     = 12;
	localparam int unsigned DAT_W     = 32;
	localparam int unsigned SEL_W     = DAT_W / 8;
	localparam int unsigned SRC_W     = 5;
	localparam int unsigned PRIO_W    = 3;
	localparam int unsigned TYPE_W    = 2;
	localparam int unsigned STK_DEPTH = 8;
	localparam int unsigned STK_IDX_W = 3;
	localparam int unsigned SP_W      = 4;
	localparam int unsigned EVT_W     = 3;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADR_W-1:0] SMR_BASE   = 12'h000;
	localparam logic [ADR_W-1:0] SVR_BASE   = 12'h080;
	localparam logic [ADR_W-1:0] TABLE_SPAN = 12'h080;
	localparam logic [ADR_W-1:0] IVR_OFS    = 12'h100;
	localparam logic [ADR_W-1:0] FVR_OFS    = 12'h104;
	localparam logic [ADR_W-1:0] ISR_OFS    = 12'h108;
	localparam logic [ADR_W-1:0] IPR_OFS    = 12'h10C;
	localparam logic [ADR_W-1:0] IMR_OFS    = 12'h110;
	localparam logic [ADR_W-1:0] CISR_OFS   = 12'h114;
	localparam logic [ADR_W-1:0] IECR_OFS   = 12'h120;
	localparam logic [ADR_W-1:0] IDCR_OFS   = 12'h124;
	localparam logic [ADR_W-1:0] ICCR_OFS   = 12'h128;
	localparam logic [ADR_W-1:0] ISCR_OFS   = 12'h12C;
	localparam logic [ADR_W-1:0] EOICR_OFS  = 12'h130;
	localparam logic [ADR_W-1:0] SPU_OFS    = 12'h134;
	localparam logic [ADR_W-1:0] EVST_OFS   = 12'h140;
	localparam logic [ADR_W-1:0] EVMSK_OFS  = 12'h144;
	localparam int unsigned      IDX_LSB    = 2;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int unsigned PRIO_LSB      = 0;
	localparam int unsigned TYPE_LSB      = 5;
	localparam int unsigned TRIG_EDGE_BIT = 0;
	localparam int unsigned TRIG_POL_BIT  = 1;
	localparam int unsigned CISR_NORM_BIT = 0;
	localparam int unsigned CISR_FAST_BIT = 1;
	localparam int unsigned EVT_SPUR_IVR  = 0;
	localparam int unsigned EVT_SPUR_FVR  = 1;
	localparam int unsigned EVT_EOI       = 2;
	localparam int unsigned FAST_SRC      = 0;
	localparam int unsigned SW_SRC        = 1;

	localparam logic [TYPE_W-1:0] TRIG_LOW_LEVEL  = 2'h0;
	localparam logic [TYPE_W-1:0] TRIG_FALL_EDGE  = 2'h1;
	localparam logic [TYPE_W-1:0] TRIG_HIGH_LEVEL = 2'h2;
	localparam logic [TYPE_W-1:0] TRIG_RISE_EDGE  = 2'h3;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WAIT,
		BUS_DONE
	} fss_bus_st_t;

endpackage : fss_pkg

// File: fss_vec_if.sv
`timescale 1ns/100ps
interface fss_vec_if #(
	parameter int unsigned AW = 5,
	parameter int unsigned DW = 32
);
	logic            we;
	logic [AW-1:0]   waddr;
	logic [DW-1:0]   wdata;
	logic [DW/8-1:0] wsel;
	logic [AW-1:0]   raddr;
	logic [DW-1:0]   rdata;

	modport ctrl (output we, waddr, wdata, wsel, raddr, input rdata);
	modport mem  (input we, waddr, wdata, wsel, raddr, output rdata);
endinterface : fss_vec_if

// File: fss_vec_mem.sv
`timescale 1ns/100ps
module fss_vec_mem
	import fss_pkg::*;
#(
	parameter int unsigned DEPTH = 32,
	parameter int unsigned AW    = 5,
	parameter int unsigned DW    = 32
) (
	input  wire logic i_clk,
	input  wire logic i_reset,
	fss_vec_if.mem    port
);

	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] mem;
		logic [DW-1:0]            rdata;
	} fss_mem_state_t;

	fss_mem_state_t mem_reg;
	fss_mem_state_t mem_next;

	// ------------------------------------------------------------
	// byte-lane write, registered read
	// ------------------------------------------------------------
	always_comb begin
		mem_next = mem_reg;
		for (int b = 0; b < DW / 8; b++) begin
			if (port.we && port.wsel[b]) begin
				mem_next.mem[port.waddr][b*8 +: 8] = port.wdata[b*8 +: 8];
			end
		end
		// read sees the old word on a same-cycle write to one entry
		mem_next.rdata = mem_reg.mem[port.raddr];
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			mem_reg <= '0;
		end else begin
			mem_reg <= mem_next;
		end
	end

	assign port.rdata = mem_reg.rdata;

endmodule : fss_vec_mem

// File: fss_core_model.sv
`timescale 1ns/100ps
module fss_core_model (
	input  wire logic i_clk,
	input  wire logic i_clr,
	input  wire logic i_normal_n,
	input  wire logic i_fast_n,
	output logic      o_irq_taken,
	output logic      o_fast_taken
);
	// --------------------------------------------------------
	// request capture
	// --------------------------------------------------------
	// the core keeps a request once seen, even if the line is
	// withdrawn later; that is what makes a late vector read spurious
	always_ff @(posedge i_clk) begin
		o_irq_taken <= i_clr ? 1'b0 : (o_irq_taken | ~i_normal_n);
		o_fast_taken <= i_clr ? 1'b0 : (o_fast_taken | ~i_fast_n);
	end
endmodule : fss_core_model

// File: fss_vic_top_tb_top.sv
`timescale 1ns/100ps
module fss_vic_top_tb_top
	import fss_pkg::*;
;
	typedef struct {
		logic             we;
		logic [ADR_W-1:0] a;
		logic [DAT_W-1:0] d;
		logic [DAT_W-1:0] e;
	} fss_row_t;

	localparam logic [DAT_W-1:0] V_SPU = 32'h0000_5a5a;
	localparam logic [DAT_W-1:0] V_FST = 32'h0000_1000;
	localparam logic [DAT_W-1:0] V_SW  = 32'h0000_2000;
	localparam logic [DAT_W-1:0] V_N2  = 32'h0000_3000;
	localparam logic [DAT_W-1:0] ALL   = 32'hffff_ffff;

	logic             clk    = 1'b0;
	logic             rst    = 1'b1;
	logic             cyc    = 1'b0;
	logic             stb    = 1'b0;
	logic             we     = 1'b0;
	logic [ADR_W-1:0] adr    = 12'h000;
	logic [SEL_W-1:0] sel    = 4'hf;
	logic [DAT_W-1:0] dat    = 32'h0000_0000;
	logic [DAT_W-1:0] rdat;
	logic [DAT_W-1:0] rd;
	logic             ack;
	logic             fin    = 1'b1;
	// external low-level sources 16..18 idle high, the rest idle low
	logic [31:2]      src    = 30'h0001_c000;
	logic             norm_n;
	logic             fast_n;
	logic             evt;
	logic             tk_clr = 1'b1;
	logic             irq_tk;
	int               error_cnt = 0;
	int               checked   = 0;

	fss_row_t rows [10] = '{
		'{1'b1, SPU_OFS, V_SPU, 32'h0},
		'{1'b0, SPU_OFS, 32'h0, V_SPU},
		'{1'b1, SVR_BASE, V_FST, 32'h0},
		'{1'b1, SVR_BASE + 12'h004, V_SW, 32'h0},
		'{1'b0, SVR_BASE, 32'h0, V_FST},
		'{1'b0, 12'h118, 32'h0, 32'h0},
		'{1'b0, IVR_OFS, 32'h0, V_SPU},
		'{1'b1, EOICR_OFS, 32'h0, 32'h0},
		'{1'b0, FVR_OFS, 32'h0, V_SPU},
		'{1'b1, EOICR_OFS, 32'h0, 32'h0}
	};

	always #4 clk = ~clk;

	fss_vic_top i_dut (
		.I_REF_CLK             (clk),
		.I_RESET               (rst),
		.I_WB_CYC              (cyc),
		.I_WB_STB              (stb),
		.I_WB_WE               (we),
		.I_WB_ADR              (adr),
		.I_WB_SEL              (sel),
		.I_WB_DAT              (dat),
		.O_WB_DAT              (rdat),
		.O_WB_ACK              (ack),
		.I_FAST_REQUEST_INPUT  (fin),
		.I_IRQ_SRC             (src),
		.O_NORMAL_REQUEST_OUT_N(norm_n),
		.O_FAST_REQUEST_OUT_N  (fast_n),
		.O_EVT_IRQ             (evt)
	);

	fss_core_model i_core (
		.i_clk      (clk),
		.i_clr      (tk_clr),
		.i_normal_n  (norm_n),
		.i_fast_n    (fast_n),
		.o_irq_taken (irq_tk),
		.o_fast_taken()
	);

	// --------------------------------------------------------
	// helpers
	// --------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string n, input logic [DAT_W-1:0] s,
			input logic [DAT_W-1:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask : tick

	task automatic wb(input logic w, input logic [ADR_W-1:0] a,
			input logic [DAT_W-1:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		// no limit here: only the watchdog may end a wait for ack
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
		wb(1'b1, a, d);
	endtask : wr

	task automatic rdm(input string n, input logic [ADR_W-1:0] a,
			input logic [DAT_W-1:0] m, input logic [DAT_W-1:0] e);
		wb(1'b0, a, 32'h0);
		chk(n, rd & m, e);
	endtask : rdm

	task automatic outs(input string n, input logic [2:0] e);
		chk(n, {29'h0, norm_n, fast_n, evt}, {29'h0, e});
	endtask : outs

	// the core model must have latched the normal request
	task automatic take_wait();
		int k;
		tk_clr <= 1'b1;
		tick(1);
		tk_clr <= 1'b0;
		for (k = 0; k < 20 && irq_tk !== 1'b1; k++) tick(1);
		chk("core took", {31'h0, irq_tk}, 32'h1);
	endtask : take_wait

	// --------------------------------------------------------
	// main sequence
	// --------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		outs("reset outs", 3'b110);
		rst <= 1'b0;
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].a, rows[i].d);
			if (!rows[i].we) chk("row read", rd, rows[i].e);
		end
		wr(SMR_BASE + 12'h004, 32'h0000_0023);
		wr(IECR_OFS, 32'h0000_0002);
		wr(ISCR_OFS, 32'h0000_0002);
		outs("sw raised", 3'b010);
		wr(ICCR_OFS, 32'h0000_0002);
		outs("sw cleared", 3'b110);
		rdm("sw pend", IPR_OFS, 32'h2, 32'h0);
		wr(ISCR_OFS, 32'h0000_0002);
		rdm("sw vec", IVR_OFS, ALL, V_SW);
		outs("ivr drops", 3'b110);
		rdm("ivr unpend", IPR_OFS, 32'h2, 32'h0);
		wr(EOICR_OFS, 32'h0);
		wr(SMR_BASE + 12'h004, 32'h0000_0003);
		wr(ISCR_OFS, 32'h0000_0002);
		rdm("level set", IPR_OFS, 32'h2, 32'h0);
		wr(SMR_BASE + 12'h004, 32'h0000_0023);
		for (int t = 0; t < 4; t++) begin
			wr(IDCR_OFS, 32'h1);
			fin <= ~t[1];
			wr(SMR_BASE, 32'(t) << TYPE_LSB);
			wr(ICCR_OFS, 32'h1);
			wr(IECR_OFS, 32'h1);
			outs("fast idle", 3'b110);
			fin <= t[1];
			tick(5);
			outs("fast act", 3'b100);
			rdm("fast vec", FVR_OFS, ALL, V_FST);
			fin <= ~t[1];
			tick(5);
			outs("fast done", 3'b110);
		end
		rdm("spur", IVR_OFS, ALL, V_SPU);
		wr(ISCR_OFS, 32'h3);
		tick(3);
		outs("spur held", 3'b110);
		wr(EOICR_OFS, 32'h0);
		tick(2);
		outs("resumed", 3'b000);
		rdm("fast edge", FVR_OFS, ALL, V_FST);
		rdm("sw again", IVR_OFS, ALL, V_SW);
		// source 1 stays current at level 3; level 4 must nest over it
		wr(SMR_BASE + 12'h008, 32'h0000_0004);
		wr(SVR_BASE + 12'h008, V_N2);
		wr(IECR_OFS, 32'h4);
		src[2] <= 1'b1;
		take_wait();
		rdm("nest vec", IVR_OFS, ALL, V_N2);
		outs("nest level", 3'b110);
		wr(EOICR_OFS, 32'h0);
		outs("nest pop", 3'b010);
		wr(EOICR_OFS, 32'h0);
		take_wait();
		src[2] <= 1'b0;
		tick(5);
		outs("withdrawn", 3'b110);
		rdm("late read", IVR_OFS, ALL, V_SPU);
		wr(EOICR_OFS, 32'h0);
		src[2] <= 1'b1;
		take_wait();
		wr(IDCR_OFS, 32'h4);
		rdm("disabled", IVR_OFS, ALL, V_SPU);
		wr(EOICR_OFS, 32'h0);
		src[2] <= 1'b0;
		// event status is sticky: flush what earlier steps left behind
		wb(1'b0, EVST_OFS, 32'h0);
		wr(EVMSK_OFS, 32'h1);
		rdm("evt spur", IVR_OFS, ALL, V_SPU);
		outs("evt on", 3'b111);
		rdm("evt stat", EVST_OFS, 32'h7, 32'h1);
		outs("evt read", 3'b110);
		wr(EOICR_OFS, 32'h0);
		outs("evt masked", 3'b110);
		rdm("evt eoi", EVST_OFS, 32'h7, 32'h4);
		// a reset in mid-run must clear the spurious vector as well
		rst <= 1'b1;
		tick(2);
		outs("mid reset", 3'b110);
		rst <= 1'b0;
		rdm("spu reset", SPU_OFS, ALL, 32'h0);
		tally_and_finish();
	end

	// whole sequence is about 330 cycles; some ninety times that means a hang
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule : fss_vic_top_tb_top
